// file: cpsec_cfg.svh
// offsets, field positions, reset values and write masks for the
// processor status and exception control block.
// assumes a word-addressed register map on an 8-bit byte address.
`ifndef CPSEC_CFG_SVH
`define CPSEC_CFG_SVH

////////////////////////////////////////////////////////////////////////
// register byte offsets
`define CPSEC_OFS_PSW 8'h00
`define CPSEC_OFS_ISP 8'h04
`define CPSEC_OFS_USP 8'h08
`define CPSEC_OFS_ITB 8'h0C
`define CPSEC_OFS_ETB 8'h10
`define CPSEC_OFS_BPC 8'h14
`define CPSEC_OFS_BSW 8'h18
`define CPSEC_OFS_FIV 8'h1C
`define CPSEC_OFS_FSW 8'h20
`define CPSEC_OFS_EVS 8'h24
`define CPSEC_OFS_EVM 8'h28

////////////////////////////////////////////////////////////////////////
// status word fields
`define CPSEC_PSW_C 0
`define CPSEC_PSW_Z 1
`define CPSEC_PSW_S 2
`define CPSEC_PSW_O 3
`define CPSEC_PSW_I 16
`define CPSEC_PSW_U 17
`define CPSEC_PSW_PM 20
`define CPSEC_PSW_IPL 27:24
`define CPSEC_PSW_WMASK 32'h0F13000F

// float status fields
`define CPSEC_FSW_OVF 0
`define CPSEC_FSW_UNS 1
`define CPSEC_FSW_OVE 8
`define CPSEC_FSW_WMASK 32'h00000103

// event status bits
`define CPSEC_EV_EXC 0
`define CPSEC_EV_IRQ 1
`define CPSEC_EV_FOV 2
`define CPSEC_EV_DBL 3
`define CPSEC_EV_MASK 32'h0000000F

////////////////////////////////////////////////////////////////////////
// reset values
`define CPSEC_RST_WORD 32'h00000000

`endif

// file: cpsec_gpr.sv
// general register file, entries 1 to 15 stored here.
// assumes entry 0 is the stack pointer held by the caller, given on sp.
`timescale 1ns/10ps
`include "cpsec_cfg.svh"
module cpsec_gpr (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // write port
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [31:0] wdata,
    // read port
    input wire logic [3:0] raddr,
    input wire logic [31:0] sp,
    output logic [31:0] rdata
);
    logic [31:0] regs [1:15];
    logic [31:0] next_rdata;

    ////////////////////////////////////////////////////////////////////
    // one storage entry per register; writes to 0 go to the caller
    for (genvar g = 1; g < 16; g++) begin : g_ent
        always_ff @(posedge clk) begin
            if (!nrst) begin
                regs[g] <= `CPSEC_RST_WORD;
            end else if (we && waddr == 4'(g)) begin
                regs[g] <= wdata;
            end
        end
    end

    // registered read; a same-cycle write is not forwarded
    always_comb begin
        next_rdata = sp;
        if (raddr != 4'h0) begin
            next_rdata = regs[raddr];
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            rdata <= `CPSEC_RST_WORD;
        end else begin
            rdata <= next_rdata;
        end
    end
endmodule : cpsec_gpr

// file: cpsec_irqc_model.sv
// interrupt controller model facing the status and exception block.
// assumes the block answers an accepted request with TAKE one cycle on.
`timescale 1ns/10ps
module cpsec_irqc_model import cpsec_pkg::*; (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // request posting from the bench
    input wire logic post,
    input wire logic [3:0] lvl,
    input wire logic [7:0] vec,
    input wire logic fast,
    // acceptance seen from the core
    input wire logic take,
    input wire cpsec_take_t kind,
    // request lines towards the core
    output logic irq_req,
    output logic [3:0] irq_level,
    output logic [7:0] irq_vec,
    output logic irq_fast
);
logic next_req;
logic [3:0] next_level;
logic [7:0] next_vec;
logic next_fast;
////////////////////////////////////////////////////////////////////////
// request flag set on arrival, core enable never consulted
always_comb begin
    next_req = irq_req;
    next_level = irq_level;
    next_vec = irq_vec;
    next_fast = irq_fast;
    if (irq_req && take && kind != CPSEC_TK_EXC) begin
        next_req = 1'b0;
        // released lines show garbage, not the old request
        next_level = ~irq_level;
        next_vec = ~irq_vec;
    end
    if (post) begin
        next_req = 1'b1;
        next_level = lvl;
        next_vec = vec;
        next_fast = fast;
    end
end
// register the request state
always_ff @(posedge clk) begin
    if (!nrst) begin
        irq_req <= 1'b0;
        irq_level <= 4'h0;
        irq_vec <= 8'h00;
        irq_fast <= 1'b0;
    end else begin
        irq_req <= next_req;
        irq_level <= next_level;
        irq_vec <= next_vec;
        irq_fast <= next_fast;
    end
end
endmodule : cpsec_irqc_model

// file: cpsec_pkg.sv
// types shared by the status and exception control block.
// assumes nothing of its surroundings.
package cpsec_pkg;
    // kind of accepted event, gray order none-exc-irq-fast
    typedef enum logic [1:0] {
        CPSEC_TK_NONE = 2'h0,
        CPSEC_TK_EXC = 2'h1,
        CPSEC_TK_IRQ = 2'h3,
        CPSEC_TK_FAST = 2'h2
    } cpsec_take_t;
endpackage : cpsec_pkg

// file: cpsec_top.sv
// status word, stack select, exception acceptance and vector control.
// assumes pipeline and interrupt controller share CLK; wishbone slave.
`timescale 1ns/10ps
`include "cpsec_cfg.svh"
module cpsec_top import cpsec_pkg::*; (
    // clock and reset
    input wire logic CLK,
    input wire logic NRST,
    // wishbone slave
    input wire logic CYC_I,
    input wire logic STB_I,
    input wire logic WE_I,
    input wire logic [7:0] ADR_I,
    input wire logic [3:0] SEL_I,
    input wire logic [31:0] DAT_I,
    output logic [31:0] DAT_O,
    output logic ACK_O,
    output logic IRQ,
    // general registers
    input wire logic GPR_WE,
    input wire logic [3:0] GPR_WADDR,
    input wire logic [31:0] GPR_WDATA,
    input wire logic [3:0] GPR_RADDR,
    output logic [31:0] GPR_RDATA,
    // pipeline events
    input wire logic FLAG_WE,
    input wire logic FLAG_C,
    input wire logic FLAG_Z,
    input wire logic FLAG_S,
    input wire logic FLAG_O,
    input wire logic WAIT_ACK,
    input wire logic TO_USER,
    input wire logic RTE,
    input wire logic [31:0] RTE_PSW,
    input wire logic RTFI,
    input wire logic EXC_REQ,
    input wire logic [7:0] EXC_NUM,
    input wire logic [31:0] PC_IN,
    // interrupt controller
    input wire logic IRQ_REQ,
    input wire logic [3:0] IRQ_LEVEL,
    input wire logic [7:0] IRQ_VEC,
    input wire logic IRQ_FAST,
    // acceptance results
    output logic TAKE,
    output cpsec_take_t TAKE_KIND,
    output logic [31:0] TARGET,
    output logic [31:0] SAVED_PSW,
    output logic [31:0] RESUME_PC,
    output logic [31:0] STATUS,
    // float unit
    input wire logic FP_OVF,
    input wire logic FP_DBL,
    output logic FP_EXC,
    output logic FP_REJECT
);
    logic [31:0] processor_status_word, irq_stack_pointer, user_stack_ptr, itb, etb, backup_program_counter, bsw, fiv, fsw, evs, evm;
    logic [31:0] next_psw, next_isp, next_usp, next_itb, next_etb;
    logic [31:0] next_bpc, next_bsw, next_fiv, next_fsw, next_evs;
    logic [31:0] next_evm, next_dat, next_target, next_saved;
    logic [31:0] next_resume, wmask, sp_cur;
    logic next_ack, next_irq, next_take, next_fexc, next_frej;
    cpsec_take_t next_kind;
    logic req, wr, rd, take_exc, take_irq, psw_wr;

    ////////////////////////////////////////////////////////////////////
    // bus decode; ack blocks a second take of the same request
    assign req = CYC_I & STB_I & ~ACK_O;
    assign wr = req & WE_I;
    assign rd = req & ~WE_I;
    assign psw_wr = wr && (ADR_I == `CPSEC_OFS_PSW);

    // byte lane enables widened to a bit mask
    for (genvar b = 0; b < 4; b++) begin : g_lane
        assign wmask[8*b+:8] = {8{SEL_I[b]}};
    end

    // active stack pointer seen as register zero
    assign sp_cur = processor_status_word[`CPSEC_PSW_U] ? user_stack_ptr : irq_stack_pointer;

    // exception beats interrupt; irq needs enable and level over mask
    assign take_exc = EXC_REQ;
    assign take_irq = ~EXC_REQ & IRQ_REQ & processor_status_word[`CPSEC_PSW_I]
        & (IRQ_LEVEL > processor_status_word[`CPSEC_PSW_IPL]);

    function automatic logic [31:0] merge(input logic [31:0] old,
            input logic [31:0] m, input logic [31:0] d);
        merge = (old & ~m) | (d & m);
    endfunction : merge

    ////////////////////////////////////////////////////////////////////
    // next-state computation, later steps override earlier ones
    always_comb begin
        next_psw = processor_status_word;
        next_isp = irq_stack_pointer;
        next_usp = user_stack_ptr;
        next_itb = itb;
        next_etb = etb;
        next_bpc = backup_program_counter;
        next_bsw = bsw;
        next_fiv = fiv;
        next_fsw = fsw;
        next_evs = evs;
        next_evm = evm;
        next_dat = DAT_O;
        next_ack = req;
        next_take = 1'b0;
        next_kind = CPSEC_TK_NONE;
        next_target = TARGET;
        next_saved = SAVED_PSW;
        next_resume = RESUME_PC;
        // register reads, unmapped reads as zero
        if (rd) begin
            case (ADR_I)
                `CPSEC_OFS_PSW: next_dat = processor_status_word;
                `CPSEC_OFS_ISP: next_dat = irq_stack_pointer;
                `CPSEC_OFS_USP: next_dat = user_stack_ptr;
                `CPSEC_OFS_ITB: next_dat = itb;
                `CPSEC_OFS_ETB: next_dat = etb;
                `CPSEC_OFS_BPC: next_dat = backup_program_counter;
                `CPSEC_OFS_BSW: next_dat = bsw;
                `CPSEC_OFS_FIV: next_dat = fiv;
                `CPSEC_OFS_FSW: next_dat = fsw;
                `CPSEC_OFS_EVS: next_dat = evs;
                `CPSEC_OFS_EVM: next_dat = evm;
                default: next_dat = `CPSEC_RST_WORD;
            endcase
        end
        // reading the event register clears it; new events set below
        if (rd && ADR_I == `CPSEC_OFS_EVS) begin
            next_evs = `CPSEC_RST_WORD;
        end
        // register writes with byte lanes
        if (wr) begin
            case (ADR_I)
                `CPSEC_OFS_PSW:
                    next_psw = merge(processor_status_word, wmask & `CPSEC_PSW_WMASK, DAT_I);
                `CPSEC_OFS_ISP: next_isp = merge(irq_stack_pointer, wmask, DAT_I);
                `CPSEC_OFS_USP: next_usp = merge(user_stack_ptr, wmask, DAT_I);
                `CPSEC_OFS_ITB: next_itb = merge(itb, wmask, DAT_I);
                `CPSEC_OFS_ETB: next_etb = merge(etb, wmask, DAT_I);
                `CPSEC_OFS_BPC: next_bpc = merge(backup_program_counter, wmask, DAT_I);
                `CPSEC_OFS_BSW:
                    next_bsw = merge(bsw, wmask & `CPSEC_PSW_WMASK, DAT_I);
                `CPSEC_OFS_FIV: next_fiv = merge(fiv, wmask, DAT_I);
                `CPSEC_OFS_FSW:
                    next_fsw = merge(fsw, wmask & `CPSEC_FSW_WMASK, DAT_I);
                `CPSEC_OFS_EVM:
                    next_evm = merge(evm, wmask & `CPSEC_EV_MASK, DAT_I);
                default: next_evm = next_evm;
            endcase
        end
        // pipeline write of register zero lands in the active pointer
        if (GPR_WE && GPR_WADDR == 4'h0) begin
            if (processor_status_word[`CPSEC_PSW_U]) begin
                next_usp = GPR_WDATA;
            end else begin
                next_isp = GPR_WDATA;
            end
        end
        // arithmetic flags, one bit each
        if (FLAG_WE) begin
            next_psw[`CPSEC_PSW_C] = FLAG_C;
            next_psw[`CPSEC_PSW_Z] = FLAG_Z;
            next_psw[`CPSEC_PSW_S] = FLAG_S;
            next_psw[`CPSEC_PSW_O] = FLAG_O;
        end
        if (WAIT_ACK) begin
            next_psw[`CPSEC_PSW_I] = 1'b1;
        end
        if (TO_USER) begin
            next_psw[`CPSEC_PSW_PM] = 1'b1;
            next_psw[`CPSEC_PSW_U] = 1'b1;
        end
        // returns restore a saved word
        if (RTE) begin
            next_psw = RTE_PSW & `CPSEC_PSW_WMASK;
        end
        if (RTFI) begin
            next_psw = bsw;
            next_resume = backup_program_counter;
        end
        // acceptance: save first, then clear enable, select and mode
        if (take_exc || take_irq) begin
            next_take = 1'b1;
            next_saved = next_psw;
            next_psw[`CPSEC_PSW_I] = 1'b0;
            next_psw[`CPSEC_PSW_U] = 1'b0;
            next_psw[`CPSEC_PSW_PM] = 1'b0;
            if (take_exc) begin
                next_kind = CPSEC_TK_EXC;
                next_target = etb + {22'h0, EXC_NUM, 2'h0};
            end else if (IRQ_FAST) begin
                next_kind = CPSEC_TK_FAST;
                next_bpc = PC_IN;
                next_bsw = next_saved;
                next_target = fiv;
            end else begin
                next_kind = CPSEC_TK_IRQ;
                next_target = itb + {22'h0, IRQ_VEC, 2'h0};
            end
        end
        // float events; hardware set wins over a software clear
        if (FP_OVF) begin
            next_fsw[`CPSEC_FSW_OVF] = 1'b1;
        end
        next_fexc = FP_OVF & fsw[`CPSEC_FSW_OVE];
        if (FP_DBL) begin
            next_fsw[`CPSEC_FSW_UNS] = 1'b1;
        end
        next_frej = FP_DBL;
        // sticky events set after the read clear so none is lost
        next_evs[`CPSEC_EV_EXC] = next_evs[`CPSEC_EV_EXC] | take_exc;
        next_evs[`CPSEC_EV_IRQ] = next_evs[`CPSEC_EV_IRQ] | take_irq;
        next_evs[`CPSEC_EV_FOV] = next_evs[`CPSEC_EV_FOV] | FP_OVF;
        next_evs[`CPSEC_EV_DBL] = next_evs[`CPSEC_EV_DBL] | FP_DBL;
        next_irq = |(next_evs & next_evm);
    end

    ////////////////////////////////////////////////////////////////////
    // state registers; enable bit and all control clear at reset
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            processor_status_word <= `CPSEC_RST_WORD;
            irq_stack_pointer <= `CPSEC_RST_WORD;
            user_stack_ptr <= `CPSEC_RST_WORD;
            itb <= `CPSEC_RST_WORD;
            etb <= `CPSEC_RST_WORD;
            backup_program_counter <= `CPSEC_RST_WORD;
            bsw <= `CPSEC_RST_WORD;
            fiv <= `CPSEC_RST_WORD;
            fsw <= `CPSEC_RST_WORD;
            evs <= `CPSEC_RST_WORD;
            evm <= `CPSEC_RST_WORD;
            DAT_O <= `CPSEC_RST_WORD;
            ACK_O <= 1'b0;
            IRQ <= 1'b0;
            TAKE <= 1'b0;
            TAKE_KIND <= CPSEC_TK_NONE;
            TARGET <= `CPSEC_RST_WORD;
            SAVED_PSW <= `CPSEC_RST_WORD;
            RESUME_PC <= `CPSEC_RST_WORD;
            STATUS <= `CPSEC_RST_WORD;
            FP_EXC <= 1'b0;
            FP_REJECT <= 1'b0;
        end else begin
            processor_status_word <= next_psw;
            irq_stack_pointer <= next_isp;
            user_stack_ptr <= next_usp;
            itb <= next_itb;
            etb <= next_etb;
            backup_program_counter <= next_bpc;
            bsw <= next_bsw;
            fiv <= next_fiv;
            fsw <= next_fsw;
            evs <= next_evs;
            evm <= next_evm;
            DAT_O <= next_dat;
            ACK_O <= next_ack;
            IRQ <= next_irq;
            TAKE <= next_take;
            TAKE_KIND <= next_kind;
            TARGET <= next_target;
            SAVED_PSW <= next_saved;
            RESUME_PC <= next_resume;
            STATUS <= next_psw;
            FP_EXC <= next_fexc;
            FP_REJECT <= next_frej;
        end
    end

    // register file; entry zero maps to the active stack pointer
    cpsec_gpr u_gpr (
        .clk(CLK),
        .nrst(NRST),
        .we(GPR_WE),
        .waddr(GPR_WADDR),
        .wdata(GPR_WDATA),
        .raddr(GPR_RADDR),
        .sp(sp_cur),
        .rdata(GPR_RDATA)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!NRST);

    AST_SP_WRITE: assert property (
        GPR_WE && GPR_WADDR == 4'h0 && !processor_status_word[`CPSEC_PSW_U]
        |=> irq_stack_pointer == $past(GPR_WDATA) && user_stack_ptr == $past(user_stack_ptr))
        else $error("r0 write missed irq stack");
    AST_EXC_CLEAR: assert property (
        EXC_REQ |=> TAKE && TAKE_KIND == CPSEC_TK_EXC
        && !processor_status_word[`CPSEC_PSW_U] && !processor_status_word[`CPSEC_PSW_PM]
        && !processor_status_word[`CPSEC_PSW_I])
        else $error("exception left bits set");
    AST_TO_USER: assert property (
        TO_USER && !EXC_REQ && !take_irq && !RTE && !RTFI
        |=> processor_status_word[`CPSEC_PSW_PM] && processor_status_word[`CPSEC_PSW_U])
        else $error("user entry not seen");
    AST_RESET_IE: assert property (
        !$past(NRST) |-> !processor_status_word[`CPSEC_PSW_I] && !TAKE)
        else $error("enable set after reset");
    AST_WAIT_IE: assert property (
        WAIT_ACK && !EXC_REQ && !take_irq && !RTE && !RTFI && !psw_wr
        |=> processor_status_word[`CPSEC_PSW_I] ##1 1'b1)
        else $error("wait did not enable");
    AST_MASK_BLOCK: assert property (
        IRQ_REQ && !EXC_REQ && IRQ_LEVEL <= processor_status_word[`CPSEC_PSW_IPL]
        |=> !TAKE)
        else $error("masked request taken");
    AST_IRQ_TAKE: assert property (
        IRQ_REQ && !EXC_REQ && !IRQ_FAST && processor_status_word[`CPSEC_PSW_I]
        && IRQ_LEVEL > processor_status_word[`CPSEC_PSW_IPL]
        |=> TAKE && TAKE_KIND == CPSEC_TK_IRQ
        && TARGET == $past(itb) + {22'h0, $past(IRQ_VEC), 2'h0})
        else $error("irq vector wrong");
    AST_FAST: assert property (
        take_irq && IRQ_FAST |=> TAKE_KIND == CPSEC_TK_FAST
        && backup_program_counter == $past(PC_IN) && bsw == SAVED_PSW
        && TARGET == $past(fiv))
        else $error("fast entry wrong");
    AST_SAVE: assert property (
        EXC_REQ && !FLAG_WE && !WAIT_ACK && !TO_USER && !RTE && !RTFI
        && !psw_wr |=> SAVED_PSW == $past(processor_status_word))
        else $error("saved status wrong");
    AST_FLAGS: assert property (
        FLAG_WE && !RTE && !RTFI |=> processor_status_word[`CPSEC_PSW_C] == $past(FLAG_C)
        && processor_status_word[`CPSEC_PSW_O] == $past(FLAG_O))
        else $error("flags not stored");
    AST_FP_OVF: assert property (
        FP_OVF |=> fsw[`CPSEC_FSW_OVF]
        && FP_EXC == $past(fsw[`CPSEC_FSW_OVE]))
        else $error("float overflow lost");
    AST_FP_DBL: assert property (
        FP_DBL |=> FP_REJECT && fsw[`CPSEC_FSW_UNS] ##1 !$past(FP_DBL)
        || FP_REJECT)
        else $error("double op not refused");

    COV_EXC: cover property (EXC_REQ ##1 TAKE);
    COV_FAST: cover property (take_irq && IRQ_FAST ##1 RTFI);
    COV_WAIT: cover property (WAIT_ACK ##1 take_irq);
    COV_IRQ: cover property (FP_OVF ##[1:3] IRQ);
endmodule : cpsec_top

// file: cpsec_top_tb.sv
// self-checking bench for the status and exception control block.
// assumes one 125 MHz clock, classic wishbone, the irq controller model.
`timescale 1ns/10ps
`include "cpsec_cfg.svh"
`define CPSEC_CHK(nm, ex, gt) begin total_checks++; \
    if ((gt) !== (ex)) begin fail_count++; \
    $display("unexpected %s exp %h got %h", nm, ex, gt); end end
module cpsec_top_tb import cpsec_pkg::*;;
logic CLK = 0, NRST = 0, CYC_I = 0, STB_I = 0, WE_I = 0, GPR_WE = 0;
logic FLAG_WE = 0, FLAG_C = 0, FLAG_Z = 0, FLAG_S = 0, FLAG_O = 0;
logic WAIT_ACK = 0, TO_USER = 0, RTE = 0, RTFI = 0, EXC_REQ = 0;
logic FP_OVF = 0, FP_DBL = 0, post = 0, pfast = 0;
logic [7:0] ADR_I = 0, EXC_NUM = 0, pvec = 0;
logic [3:0] SEL_I = 4'hF, GPR_WADDR = 0, GPR_RADDR = 0, plvl = 0;
logic [31:0] DAT_I = 0, GPR_WDATA = 0, RTE_PSW = 0, PC_IN = 0, d;
logic [31:0] DAT_O, GPR_RDATA, TARGET, SAVED_PSW, RESUME_PC, STATUS;
logic ACK_O, IRQ, TAKE, FP_EXC, FP_REJECT, IRQ_REQ, IRQ_FAST;
logic [3:0] IRQ_LEVEL;
logic [7:0] IRQ_VEC;
cpsec_take_t TAKE_KIND;
int fail_count = 0, total_checks = 0, cycles = 0, takes = 0, t0;
////////////////////////////////////////////////////////////////////////
cpsec_top i_cpsec_top (.CLK, .NRST, .CYC_I, .STB_I, .WE_I, .ADR_I,
    .SEL_I, .DAT_I, .DAT_O, .ACK_O, .IRQ, .GPR_WE, .GPR_WADDR,
    .GPR_WDATA, .GPR_RADDR, .GPR_RDATA, .FLAG_WE, .FLAG_C, .FLAG_Z,
    .FLAG_S, .FLAG_O, .WAIT_ACK, .TO_USER, .RTE, .RTE_PSW, .RTFI,
    .EXC_REQ, .EXC_NUM, .PC_IN, .IRQ_REQ, .IRQ_LEVEL, .IRQ_VEC,
    .IRQ_FAST, .TAKE, .TAKE_KIND, .TARGET, .SAVED_PSW, .RESUME_PC,
    .STATUS, .FP_OVF, .FP_DBL, .FP_EXC, .FP_REJECT);
cpsec_irqc_model i_cpsec_irqc_model (.clk(CLK), .nrst(NRST),
    .post(post), .lvl(plvl), .vec(pvec), .fast(pfast), .take(TAKE),
    .kind(TAKE_KIND), .irq_req(IRQ_REQ), .irq_level(IRQ_LEVEL),
    .irq_vec(IRQ_VEC), .irq_fast(IRQ_FAST));
////////////////////////////////////////////////////////////////////////
// clock, take counter and hang guard
initial begin
    forever #4 CLK = ~CLK;
end
always @(posedge CLK) begin
    cycles++;
    if (TAKE === 1'b1) takes++;
    if (cycles == 3000) begin
        fail_count++;
        close_out();
    end
end
////////////////////////////////////////////////////////////////////////
// classic cycle: hold until ack is sampled, then idle one cycle
task automatic wb(input logic w, input logic [7:0] a,
                  input logic [31:0] wd, output logic [31:0] rd);
    @(posedge CLK);
    CYC_I <= 1'b1;
    STB_I <= 1'b1;
    WE_I <= w;
    ADR_I <= a;
    DAT_I <= wd;
    do @(posedge CLK); while (ACK_O !== 1'b1);
    rd = DAT_O;
    CYC_I <= 1'b0;
    STB_I <= 1'b0;
    WE_I <= 1'b0;
    @(posedge CLK);
endtask : wb
task automatic wr(input logic [7:0] a, input logic [31:0] v);
    wb(1'b1, a, v, d);
endtask : wr
task automatic rdc(input logic [7:0] a, input logic [31:0] ex);
    wb(1'b0, a, 32'h0, d);
    `CPSEC_CHK("read data", ex, d)
endtask : rdc
task automatic tick(input int n);
    repeat (n) @(posedge CLK);
    #1;
endtask : tick
task automatic post_irq(input logic [3:0] l, input logic [7:0] v,
                        input logic f);
    @(posedge CLK);
    post <= 1'b1;
    plvl <= l;
    pvec <= v;
    pfast <= f;
    @(posedge CLK);
    post <= 1'b0;
endtask : post_irq
// bounded wait for the acceptance pulse
task automatic wait_take();
    // look past the edge first: the pulse stands only one cycle
    #1;
    for (int i = 0; i < 20 && TAKE !== 1'b1; i++) tick(1);
    `CPSEC_CHK("take", 1'b1, TAKE)
endtask : wait_take
task automatic no_take();
    t0 = takes;
    tick(6);
    `CPSEC_CHK("quiet", t0, takes)
endtask : no_take
////////////////////////////////////////////////////////////////////////
// map, masks and stack select
task automatic s_regs();
    `CPSEC_CHK("status", 32'h0, STATUS)
    rdc(8'h00, 32'h00000000);
    wr(8'h3C, 32'hFFFFFFFF);
    rdc(8'h3C, 32'h00000000);
    wr(8'h04, 32'h00000100);
    wr(8'h08, 32'h00000200);
    wr(8'h0C, 32'h00001000);
    wr(8'h10, 32'h00002000);
    wr(8'h1C, 32'h00003000);
    wr(8'h28, 32'h00000003);
    wr(8'h00, 32'hFFFFFFFF);
    `CPSEC_CHK("status", `CPSEC_PSW_WMASK, STATUS)
    wr(8'h00, 32'h05010000);
    `CPSEC_CHK("sp", 32'h100, GPR_RDATA)
    @(posedge CLK);
    GPR_WE <= 1'b1;
    GPR_WADDR <= 4'h3;
    GPR_WDATA <= 32'h0000ABCD;
    GPR_RADDR <= 4'h3;
    @(posedge CLK);
    // register zero lands in the irq stack pointer while select is 0
    GPR_WADDR <= 4'h0;
    GPR_WDATA <= 32'h00000180;
    @(posedge CLK);
    GPR_WE <= 1'b0;
    tick(1);
    `CPSEC_CHK("gpr", 32'hABCD, GPR_RDATA)
    @(posedge CLK);
    GPR_RADDR <= 4'h0;
    TO_USER <= 1'b1;
    @(posedge CLK);
    TO_USER <= 1'b0;
    FLAG_WE <= 1'b1;
    FLAG_C <= 1'b1;
    FLAG_O <= 1'b1;
    @(posedge CLK);
    FLAG_WE <= 1'b0;
    tick(1);
    `CPSEC_CHK("status", 32'h05130009, STATUS)
    `CPSEC_CHK("sp", 32'h200, GPR_RDATA)
    rdc(8'h04, 32'h00000180);
endtask : s_regs
////////////////////////////////////////////////////////////////////////
// exception, then ordinary irq against enable and mask level
task automatic s_exc_irq();
    @(posedge CLK);
    EXC_NUM <= 8'h03;
    EXC_REQ <= 1'b1;
    @(posedge CLK);
    EXC_REQ <= 1'b0;
    wait_take();
    `CPSEC_CHK("kind", CPSEC_TK_EXC, TAKE_KIND)
    `CPSEC_CHK("target", 32'h200C, TARGET)
    `CPSEC_CHK("saved", 32'h05130009, SAVED_PSW)
    `CPSEC_CHK("status", 32'h05000009, STATUS)
    post_irq(4'h9, 8'h02, 1'b0);
    no_take();
    post_irq(4'h5, 8'h02, 1'b0);
    @(posedge CLK);
    WAIT_ACK <= 1'b1;
    @(posedge CLK);
    WAIT_ACK <= 1'b0;
    tick(1);
    `CPSEC_CHK("status", 32'h05010009, STATUS)
    no_take();
    post_irq(4'h6, 8'h02, 1'b0);
    wait_take();
    `CPSEC_CHK("kind", CPSEC_TK_IRQ, TAKE_KIND)
    `CPSEC_CHK("target", 32'h1008, TARGET)
    `CPSEC_CHK("saved", 32'h05010009, SAVED_PSW)
    `CPSEC_CHK("status", 32'h05000009, STATUS)
    `CPSEC_CHK("irq", 1'b1, IRQ)
    rdc(8'h24, 32'h00000003);
    tick(1);
    `CPSEC_CHK("irq", 1'b0, IRQ)
endtask : s_exc_irq
////////////////////////////////////////////////////////////////////////
// fast irq, backups, returns
task automatic s_fast();
    @(posedge CLK);
    WAIT_ACK <= 1'b1;
    PC_IN <= 32'h00000080;
    @(posedge CLK);
    WAIT_ACK <= 1'b0;
    post_irq(4'h7, 8'h09, 1'b1);
    wait_take();
    `CPSEC_CHK("kind", CPSEC_TK_FAST, TAKE_KIND)
    `CPSEC_CHK("target", 32'h3000, TARGET)
    rdc(8'h14, 32'h00000080);
    rdc(8'h18, 32'h05010009);
    @(posedge CLK);
    RTFI <= 1'b1;
    @(posedge CLK);
    RTFI <= 1'b0;
    tick(1);
    `CPSEC_CHK("status", 32'h05010009, STATUS)
    `CPSEC_CHK("resume", 32'h80, RESUME_PC)
    @(posedge CLK);
    RTE_PSW <= 32'hFFFFFFFF;
    RTE <= 1'b1;
    @(posedge CLK);
    RTE <= 1'b0;
    tick(1);
    `CPSEC_CHK("status", `CPSEC_PSW_WMASK, STATUS)
    rdc(8'h24, 32'h00000002);
endtask : s_fast
////////////////////////////////////////////////////////////////////////
// float overflow and refused double precision, both masked off irq
task automatic s_fp();
    wr(8'h20, 32'h00000100);
    FP_OVF <= 1'b1;
    @(posedge CLK);
    FP_OVF <= 1'b0;
    #1;
    `CPSEC_CHK("fp exc", 1'b1, FP_EXC)
    rdc(8'h20, 32'h00000101);
    FP_DBL <= 1'b1;
    @(posedge CLK);
    FP_DBL <= 1'b0;
    #1;
    `CPSEC_CHK("fp reject", 1'b1, FP_REJECT)
    rdc(8'h20, 32'h00000103);
    `CPSEC_CHK("irq", 1'b0, IRQ)
    rdc(8'h24, 32'h0000000C);
endtask : s_fp
////////////////////////////////////////////////////////////////////////
// verdict and end of run
task close_out();
    if (fail_count == 0 && total_checks > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask : close_out
// main sequence
initial begin
    repeat (20) @(posedge CLK);
    NRST <= 1'b1;
    tick(1);
    s_regs();
    s_exc_irq();
    s_fast();
    s_fp();
    close_out();
end
endmodule : cpsec_top_tb
